// File: hdl/stk_pkg.sv
package stk_pkg;
	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int W_W = 24;
	localparam int CLK_NS = 100;
	localparam int TENTH_NS = 100000000;
	localparam int TENTH_CYCLES = TENTH_NS / CLK_NS;
	localparam logic [3:0] TENTHS_PER_SEC = 4'hA;
	localparam logic [12:0] SEC_PER_MIN = 13'h03C;
	localparam logic signed [44:0] FACTOR_SCALE = 45'sh0186A0;
	localparam logic [12:0] WARM_RST = 13'h0000;
	// ----------------------------------------------------------------
	// Display views
	// ----------------------------------------------------------------
	localparam logic [1:0] VIEW_GROSS = 2'h0;
	localparam logic [1:0] VIEW_NET = 2'h1;
	localparam logic [1:0] VIEW_TARE = 2'h2;
	// ----------------------------------------------------------------
	// Select key actions
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_NET_GROSS = 4'h1;
	localparam logic [3:0] SEL_NET_TARE = 4'h2;
	localparam logic [3:0] SEL_CYCLE = 4'h3;
	localparam logic [3:0] SEL_UNITS = 4'h4;
	localparam logic [3:0] SEL_PROMPT = 4'h5;
	localparam logic [3:0] SEL_STORE_ID = 4'h6;
	localparam logic [3:0] SEL_RECALL_ID = 4'h7;
	localparam logic [3:0] SEL_SP1 = 4'h8;
	localparam logic [3:0] SEL_SP2 = 4'h9;
	localparam logic [3:0] SEL_DYNAMIC = 4'hA;
	localparam logic [3:0] SEL_TOTAL = 4'hB;
	localparam logic [3:0] SEL_SUBTOTAL = 4'hC;
	localparam logic [3:0] SEL_PRINT_ACCUM = 4'hD;
	// ----------------------------------------------------------------
	// Entry kinds and states
	// ----------------------------------------------------------------
	localparam logic [1:0] ENTRY_TARE = 2'h0;
	localparam logic [1:0] ENTRY_SP1 = 2'h1;
	localparam logic [1:0] ENTRY_SP2 = 2'h2;
	typedef enum logic [3:0] {
		ST_WARM = 4'h1,
		ST_RUN = 4'h2,
		ST_ENTRY = 4'h4,
		ST_RECALL = 4'h8
	} stk_state_e;
endpackage

// File: hdl/stk_motion.sv
`timescale 1ns/1ns
module stk_motion (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic signed [23:0] weight,
	input wire logic tenth_tick,
	input wire logic [9:0] motion_range,
	input wire logic [3:0] motion_interval,
	output logic no_motion
);
	logic signed [23:0] ref_w;
	logic [3:0] still_cnt;
	logic signed [24:0] diff;
	logic [24:0] mag;
	logic moved;

	assign diff = 25'(weight) - 25'(ref_w);
	assign mag = diff[24] ? 25'(-diff) : 25'(diff);
	assign moved = mag > {15'h0000, motion_range};

	// Restarting the interval on any excursion keeps a slow drift from passing as stable.
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ref_w <= 24'sh000000;
			still_cnt <= 4'h0;
			no_motion <= 1'b0;
		end
		else
		begin
			if (moved)
			begin
				ref_w <= weight;
				still_cnt <= 4'h0;
			end
			else if (tenth_tick && still_cnt < motion_interval)
				still_cnt <= still_cnt + 4'h1;
			no_motion <= !moved && still_cnt >= motion_interval;
		end
	end
endmodule // stk_motion

// File: hdl/stk_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Warm-up delay in minutes, countdown shown
// - Master tare off blocks all tare
// - Tare key captures weight, shows net
// - Confirmed entered value becomes preset tare
// - Armed auto tare above threshold when still
// - Rearm auto tare below reset threshold
// - Optional stillness needed before rearm
// - Clear tare after rise then fall
// - Optional stillness needed before threshold clear
// - Choose clear after print or threshold
// - Lockout with auto clear: clear at zero
// - Function key recalls tare or gross
// - Sign correction keeps printed net positive
// - Tare and print wait for stillness
// - Key timeout 0 to 15 s, zero disables
// - Timeout restores the previous condition
// - Unit toggle swaps main and second unit
// - Custom unit is weight times factor divided by 100000
// - Custom label shown with converted weight
// - Select key runs one configured action
// - Stillness needs range held for interval
module stk_ctrl #(
	parameter int TENTH_CYCLES = stk_pkg::TENTH_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic signed [23:0] weight,
	input wire logic weight_valid,
	input wire logic [9:0] motion_range,
	input wire logic [3:0] motion_interval,
	input wire logic [6:0] warmup_minutes,
	input wire logic [3:0] key_timeout_sec,
	input wire logic tare_enable,
	input wire logic tare_clear_lockout,
	input wire logic key_capture_tare_enable,
	input wire logic entered_tare_enable,
	input wire logic automatic_tare_enable,
	input wire logic signed [23:0] auto_tare_thresh,
	input wire logic signed [23:0] auto_rearm_thresh,
	input wire logic auto_rearm_motion_check,
	input wire logic auto_clear_enable,
	input wire logic clear_after_print,
	input wire logic signed [23:0] clear_thresh,
	input wire logic clear_motion_check,
	input wire logic tare_recall_enable,
	input wire logic gross_recall_enable,
	input wire logic sign_correct_enable,
	input wire logic second_unit_enable,
	input wire logic [19:0] custom_factor,
	input wire logic [23:0] custom_label,
	input wire logic [3:0] select_action,
	input wire logic key_tare,
	input wire logic key_tare_entry,
	input wire logic key_function,
	input wire logic key_select,
	input wire logic key_unit,
	input wire logic key_print,
	input wire logic entry_confirm,
	input wire logic signed [23:0] entry_value,
	output logic signed [23:0] display_value,
	output logic [1:0] display_view,
	output logic display_second_unit,
	output logic [23:0] display_label,
	output logic warmup_active,
	output logic [12:0] warmup_remaining_sec,
	output logic entry_active,
	output logic [1:0] entry_kind,
	output logic recall_active,
	output logic no_motion,
	output logic signed [23:0] tare_value,
	output logic net_mode,
	output logic signed [23:0] setpoint1,
	output logic signed [23:0] setpoint2,
	output logic print_strobe,
	output logic signed [23:0] print_gross,
	output logic signed [23:0] print_tare,
	output logic signed [23:0] print_net,
	output logic select_cmd_valid,
	output logic [3:0] select_cmd_code
);
	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	logic [19:0] tenth_cnt;
	logic [3:0] tenth_of_sec;
	logic tenth_tick;
	logic sec_tick;
	assign tenth_tick = tenth_cnt == 20'(TENTH_CYCLES - 1);
	assign sec_tick = tenth_tick && tenth_of_sec == stk_pkg::TENTHS_PER_SEC - 4'h1;

	always_ff @(posedge sys_clk)
	begin
		if (srst || tenth_tick)
			tenth_cnt <= 20'h00000;
		else
			tenth_cnt <= tenth_cnt + 20'h00001;
		if (srst || sec_tick)
			tenth_of_sec <= 4'h0;
		else if (tenth_tick)
			tenth_of_sec <= tenth_of_sec + 4'h1;
	end

	// ----------------------------------------------------------------
	// Weights and decodes
	// ----------------------------------------------------------------
	logic signed [23:0] gross;
	logic signed [23:0] net;
	logic signed [23:0] next_gross;
	logic armed;
	logic clr_above;
	logic tare_pend;
	logic print_pend;
	logic warm_loaded;
	logic [3:0] to_cnt;
	logic [1:0] saved_view;
	logic unit_second;
	stk_pkg::stk_state_e state;
	stk_pkg::stk_state_e next_state;
	logic [1:0] next_view;

	wire in_run = state == stk_pkg::ST_RUN;
	wire in_entry = state == stk_pkg::ST_ENTRY;
	wire in_recall = state == stk_pkg::ST_RECALL;
	wire gross_zero = gross == 24'sh000000;
	wire do_key_tare = tare_enable && tare_pend && no_motion;
	wire auto_ok = tare_enable && automatic_tare_enable;
	wire do_auto_tare = auto_ok && armed && gross > auto_tare_thresh && no_motion;
	wire rearm = gross < auto_rearm_thresh && (!auto_rearm_motion_check || no_motion);
	wire do_entry_tare = in_entry && entry_confirm && entry_kind == stk_pkg::ENTRY_TARE
		&& tare_enable && entered_tare_enable;
	wire capture = do_key_tare || do_auto_tare;
	wire print_fire = print_pend && no_motion;
	wire clr_fall = clr_above && gross < clear_thresh
		&& (!clear_motion_check || no_motion);
	wire clr_by_mode = clear_after_print ? print_fire : clr_fall;
	wire clear_req = tare_enable && auto_clear_enable && net_mode
		&& (tare_clear_lockout ? gross_zero : clr_by_mode);
	wire timed_out = key_timeout_sec != 4'h0 && to_cnt >= key_timeout_sec;
	wire sel_run = in_run && key_select;
	wire sel_sp = sel_run && (select_action == stk_pkg::SEL_SP1
		|| select_action == stk_pkg::SEL_SP2);
	wire sel_ext = sel_run && select_action >= stk_pkg::SEL_PROMPT
		&& select_action <= stk_pkg::SEL_PRINT_ACCUM && !sel_sp;
	wire recall_go = in_run && key_function && (tare_recall_enable || gross_recall_enable);
	wire entry_go = in_run && key_tare_entry && tare_enable && entered_tare_enable;

	assign net = gross - tare_value;
	assign next_gross = weight_valid ? weight : gross;

	// Stillness is judged on the reading being loaded, so a fresh step never looks settled.
	stk_motion stk_motion_i (
		.sys_clk(sys_clk),
		.srst(srst),
		.weight(next_gross),
		.tenth_tick(tenth_tick),
		.motion_range(motion_range),
		.motion_interval(motion_interval),
		.no_motion(no_motion)
	);

	// ----------------------------------------------------------------
	// Operating state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			stk_pkg::ST_WARM:
				if (warm_loaded && warmup_remaining_sec == 13'h0000)
					next_state = stk_pkg::ST_RUN;
			stk_pkg::ST_RUN:
				if (recall_go)
					next_state = stk_pkg::ST_RECALL;
				else if (entry_go || sel_sp)
					next_state = stk_pkg::ST_ENTRY;
			stk_pkg::ST_ENTRY:
				if (entry_confirm || timed_out)
					next_state = stk_pkg::ST_RUN;
			stk_pkg::ST_RECALL:
				if (key_function || timed_out)
					next_state = stk_pkg::ST_RUN;
			default:
				next_state = stk_pkg::ST_RUN;
		endcase
	end

	always_comb
	begin
		next_view = display_view;
		if (clear_req && !capture && !do_entry_tare)
			next_view = stk_pkg::VIEW_GROSS;
		else if (capture || do_entry_tare)
			next_view = stk_pkg::VIEW_NET;
		else if (recall_go)
			next_view = tare_recall_enable ? stk_pkg::VIEW_TARE : stk_pkg::VIEW_GROSS;
		else if (in_recall && (key_function || timed_out))
			next_view = saved_view;
		else if (sel_run)
		begin
			case (select_action)
				stk_pkg::SEL_NET_GROSS:
					next_view = display_view == stk_pkg::VIEW_NET ?
						stk_pkg::VIEW_GROSS : stk_pkg::VIEW_NET;
				stk_pkg::SEL_NET_TARE:
					next_view = display_view == stk_pkg::VIEW_TARE ?
						stk_pkg::VIEW_NET : stk_pkg::VIEW_TARE;
				stk_pkg::SEL_CYCLE:
					next_view = display_view == stk_pkg::VIEW_NET ? stk_pkg::VIEW_GROSS :
						display_view == stk_pkg::VIEW_GROSS ? stk_pkg::VIEW_TARE :
						stk_pkg::VIEW_NET;
				default:
					next_view = display_view;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= stk_pkg::ST_WARM;
			display_view <= stk_pkg::VIEW_GROSS;
			saved_view <= stk_pkg::VIEW_GROSS;
			to_cnt <= 4'h0;
			entry_kind <= stk_pkg::ENTRY_TARE;
		end
		else
		begin
			state <= next_state;
			display_view <= next_view;
			if (recall_go)
				saved_view <= display_view;
			if (state != next_state)
				to_cnt <= 4'h0;
			else if (sec_tick && !timed_out)
				to_cnt <= to_cnt + 4'h1;
			if (entry_go)
				entry_kind <= stk_pkg::ENTRY_TARE;
			else if (sel_sp)
				entry_kind <= select_action == stk_pkg::SEL_SP1 ?
					stk_pkg::ENTRY_SP1 : stk_pkg::ENTRY_SP2;
		end
	end

	// ----------------------------------------------------------------
	// Warm-up countdown
	// ----------------------------------------------------------------
	// The delay is sampled on the first edge after reset release, never under reset.
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			warm_loaded <= 1'b0;
			warmup_remaining_sec <= stk_pkg::WARM_RST;
		end
		else if (!warm_loaded)
		begin
			warm_loaded <= 1'b1;
			warmup_remaining_sec <= 13'(warmup_minutes * stk_pkg::SEC_PER_MIN);
		end
		else if (sec_tick && warmup_remaining_sec != 13'h0000)
			warmup_remaining_sec <= warmup_remaining_sec - 13'h0001;
	end

	// ----------------------------------------------------------------
	// Tare, triggers and print
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			gross <= 24'sh000000;
			tare_value <= 24'sh000000;
			net_mode <= 1'b0;
			armed <= 1'b1;
			clr_above <= 1'b0;
			tare_pend <= 1'b0;
			print_pend <= 1'b0;
			setpoint1 <= 24'sh000000;
			setpoint2 <= 24'sh000000;
		end
		else
		begin
			if (weight_valid)
				gross <= weight;
			if (capture || do_entry_tare)
			begin
				tare_value <= capture ? gross : entry_value;
				net_mode <= 1'b1;
			end
			else if (clear_req)
			begin
				tare_value <= 24'sh000000;
				net_mode <= 1'b0;
			end
			if (do_auto_tare)
				armed <= 1'b0;
			else if (rearm)
				armed <= 1'b1;
			if (gross > clear_thresh)
				clr_above <= 1'b1;
			else if (clr_fall)
				clr_above <= 1'b0;
			if (in_run && key_tare && tare_enable && key_capture_tare_enable)
				tare_pend <= 1'b1;
			else if (do_key_tare || !tare_enable)
				tare_pend <= 1'b0;
			if (in_run && key_print)
				print_pend <= 1'b1;
			else if (print_fire)
				print_pend <= 1'b0;
			if (in_entry && entry_confirm && entry_kind == stk_pkg::ENTRY_SP1)
				setpoint1 <= entry_value;
			if (in_entry && entry_confirm && entry_kind == stk_pkg::ENTRY_SP2)
				setpoint2 <= entry_value;
		end
	end

	wire swap = sign_correct_enable && gross < tare_value;
	wire signed [23:0] pr_gross = swap ? tare_value : gross;
	wire signed [23:0] pr_tare = swap ? gross : tare_value;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			print_strobe <= 1'b0;
			print_gross <= 24'sh000000;
			print_tare <= 24'sh000000;
			print_net <= 24'sh000000;
			select_cmd_valid <= 1'b0;
			select_cmd_code <= stk_pkg::SEL_NONE;
		end
		else
		begin
			print_strobe <= print_fire;
			if (print_fire)
			begin
				print_gross <= pr_gross;
				print_tare <= pr_tare;
				print_net <= pr_gross - pr_tare;
			end
			select_cmd_valid <= sel_ext;
			if (sel_ext)
				select_cmd_code <= select_action;
		end
	end

	// ----------------------------------------------------------------
	// Units and display
	// ----------------------------------------------------------------
	wire unit_go = in_run && (key_unit || (key_select && select_action == stk_pkg::SEL_UNITS));
	wire signed [23:0] shown = display_view == stk_pkg::VIEW_NET ? net :
		display_view == stk_pkg::VIEW_TARE ? tare_value : gross;
	wire signed [44:0] conv_prod = 45'(shown) * 45'($signed({1'b0, custom_factor}));
	wire signed [44:0] conv_q = conv_prod / stk_pkg::FACTOR_SCALE;
	// Converted values are truncated to the display width; the factor must keep them in range.
	wire signed [23:0] unit_val = unit_second ? conv_q[23:0] : shown;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			unit_second <= 1'b0;
			display_value <= 24'sh000000;
			display_second_unit <= 1'b0;
			display_label <= 24'h000000;
			warmup_active <= 1'b1;
			entry_active <= 1'b0;
			recall_active <= 1'b0;
		end
		else
		begin
			if (!second_unit_enable)
				unit_second <= 1'b0;
			else if (unit_go)
				unit_second <= !unit_second;
			display_value <= state == stk_pkg::ST_WARM ?
				24'(warmup_remaining_sec) : unit_val;
			display_second_unit <= unit_second;
			display_label <= unit_second ? custom_label : 24'h000000;
			warmup_active <= next_state == stk_pkg::ST_WARM;
			entry_active <= next_state == stk_pkg::ST_ENTRY;
			recall_active <= next_state == stk_pkg::ST_RECALL;
		end
	end
endmodule // stk_ctrl

// File: bench/stk_frontend.sv
`timescale 1ns/1ns
module stk_frontend (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic signed [23:0] target,
	output logic signed [23:0] weight,
	output logic weight_valid
);
	// ----------------------------------------
	// Reading source
	// ----------------------------------------
	logic [1:0] phase;
	// Between readings the bus carries the inverse, so a stale sample shows up.
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			phase <= 2'h0;
			weight_valid <= 1'b0;
			weight <= 24'h000000;
		end
		else
		begin
			phase <= phase + 2'h1;
			weight_valid <= (phase == 2'h3);
			weight <= (phase == 2'h3) ? target : ~target;
		end
	end
endmodule // stk_frontend

// File: bench/stk_ctrl_chk.sv
`timescale 1ns/1ns
module stk_ctrl_chk (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic tare_enable,
	input wire logic sign_correct_enable,
	input wire logic second_unit_enable,
	input wire logic tare_recall_enable,
	input wire logic [23:0] custom_label,
	input wire logic [1:0] display_view,
	input wire logic display_second_unit,
	input wire logic [23:0] display_label,
	input wire logic warmup_active,
	input wire logic entry_active,
	input wire logic recall_active,
	input wire logic no_motion,
	input wire logic signed [23:0] tare_value,
	input wire logic net_mode,
	input wire logic print_strobe,
	input wire logic signed [23:0] print_gross,
	input wire logic signed [23:0] print_tare,
	input wire logic signed [23:0] print_net,
	input wire logic select_cmd_valid,
	input wire logic [3:0] select_cmd_code
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	property p_warm;
		warmup_active |-> !entry_active && !recall_active && !net_mode;
	endproperty
	a_warm: assert property (p_warm) else $error("activity in warm-up");
	property p_lock;
		!tare_enable && tare_value == 24'h000000 |=> tare_value == 24'h000000;
	endproperty
	a_lock: assert property (p_lock) else $error("tare while disabled");
	property p_clr;
		$fell(net_mode) |-> tare_value == 24'h000000 && display_view == stk_pkg::VIEW_GROSS;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left tare or view");
	property p_still;
		print_strobe |-> $past(no_motion);
	endproperty
	a_still: assert property (p_still) else $error("print without stillness");
	property p_sign;
		print_strobe && sign_correct_enable |-> print_net >= 0 && print_net == print_gross - print_tare;
	endproperty
	a_sign: assert property (p_sign) else $error("printed net wrong");
	property p_label;
		display_label == (display_second_unit ? custom_label : 24'h000000);
	endproperty
	a_label: assert property (p_label) else $error("label mismatch");
	property p_sel;
		select_cmd_valid |-> select_cmd_code inside {4'h5, 4'h6, 4'h7, [4'hA:4'hD]};
	endproperty
	a_sel: assert property (p_sel) else $error("bad select code");
	property p_rcl;
		$rose(recall_active) |->
			display_view == (tare_recall_enable ? stk_pkg::VIEW_TARE : stk_pkg::VIEW_GROSS);
	endproperty
	a_rcl: assert property (p_rcl) else $error("recall view wrong");
	property p_unit;
		$rose(display_second_unit) |-> second_unit_enable;
	endproperty
	a_unit: assert property (p_unit) else $error("unit switch disabled");
	c_print: cover property (print_strobe);
	c_rcl: cover property ($rose(recall_active));
	c_net: cover property ($rose(net_mode));
endmodule // stk_ctrl_chk

// File: bench/test_stk_ctrl.sv
`timescale 1ns/1ns
module test_stk_ctrl;
	// ----------------------------------------
	// Stimulus and hookup
	// ----------------------------------------
	logic sys_clk = 0;
	logic srst = 1;
	logic signed [23:0] target = 24'h000000, entry_value = 24'h000000;
	logic signed [23:0] auto_tare_thresh = 24'h00012C, auto_rearm_thresh = 24'h000032;
	logic signed [23:0] clear_thresh = 24'h000190;
	logic [9:0] motion_range = 10'h002;
	logic [3:0] motion_interval = 4'h1, key_timeout_sec = 4'h1, select_action = 4'h0;
	logic [6:0] warmup_minutes = 7'h01, k = 7'h00;
	logic tare_enable = 0, tare_clear_lockout = 0, key_capture_tare_enable = 1;
	logic entered_tare_enable = 1, automatic_tare_enable = 0, auto_rearm_motion_check = 0;
	logic auto_clear_enable = 0, clear_after_print = 0, clear_motion_check = 0;
	logic tare_recall_enable = 1, gross_recall_enable = 0, sign_correct_enable = 1;
	logic second_unit_enable = 1;
	logic [19:0] custom_factor = 20'h249F0;
	logic [23:0] custom_label = 24'h4B4C42, display_label;
	logic signed [23:0] weight, display_value, tare_value, print_gross, print_tare, print_net;
	logic signed [23:0] pg, pt, pn, setpoint1, setpoint2;
	logic [12:0] warmup_remaining_sec;
	logic [1:0] display_view, entry_kind;
	logic [3:0] select_cmd_code, sel_seen = 4'h0;
	logic [3:0] codes [7] = '{4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD};
	logic weight_valid, display_second_unit, warmup_active, entry_active, recall_active;
	logic no_motion, net_mode, print_strobe, select_cmd_valid;
	int mismatches = 0, samples_checked = 0, cyc = 0, n;
	stk_frontend stk_frontend_i (.sys_clk, .srst, .target, .weight, .weight_valid);
	stk_ctrl #(.TENTH_CYCLES(10)) stk_ctrl_i (.sys_clk, .srst, .weight, .weight_valid,
		.motion_range, .motion_interval, .warmup_minutes, .key_timeout_sec, .tare_enable,
		.tare_clear_lockout, .key_capture_tare_enable, .entered_tare_enable,
		.automatic_tare_enable, .auto_tare_thresh, .auto_rearm_thresh,
		.auto_rearm_motion_check, .auto_clear_enable, .clear_after_print, .clear_thresh,
		.clear_motion_check, .tare_recall_enable, .gross_recall_enable, .sign_correct_enable,
		.second_unit_enable, .custom_factor, .custom_label, .select_action,
		.key_tare(k[0]), .key_tare_entry(k[1]), .key_function(k[2]), .key_select(k[3]),
		.key_unit(k[4]), .key_print(k[5]), .entry_confirm(k[6]), .entry_value,
		.display_value, .display_view, .display_second_unit, .display_label, .warmup_active,
		.warmup_remaining_sec, .entry_active, .entry_kind, .recall_active, .no_motion,
		.tare_value, .net_mode, .setpoint1, .setpoint2, .print_strobe, .print_gross,
		.print_tare, .print_net, .select_cmd_valid, .select_cmd_code);
	always #50 sys_clk = ~sys_clk;
	// Pulses are caught here so a check need not land on the pulse cycle itself.
	always @(posedge sys_clk)
	begin
		if (select_cmd_valid === 1'b1)
			sel_seen <= select_cmd_code;
		if (print_strobe === 1'b1)
			{pg, pt, pn} <= {print_gross, print_tare, print_net};
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			report_and_stop;
		end
	end
	task automatic step(input int c);
		repeat (c) @(negedge sys_clk);
	endtask
	task automatic press(input int i);
		k[i] = 1'b1;
		step(1);
		k[i] = 1'b0;
		step(1);
	endtask
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		step(12);
		srst = 0;
		step(5);
		chk("warm_rem", 24'h00003C, warmup_remaining_sec);
		chk("warm_disp", 24'h00003C, display_value);
		n = 0;
		while (warmup_active !== 1'b0 && n < 7000)
		begin
			step(1);
			n++;
		end
		chk("warm_len", 24'h000001, n > 5900 && n < 6010);
		target = 24'h0001F4;
		step(40);
		press(0);
		step(40);
		chk("tare_off", 24'h000000, tare_value);
		tare_enable = 1;
		press(0);
		step(40);
		chk("tare_pb", 24'h0001F4, tare_value);
		chk("view_net", stk_pkg::VIEW_NET, display_view);
		target = 24'h000320;
		step(40);
		chk("net", 24'h00012C, display_value);
		press(1);
		step(4);
		chk("entry", 24'h000001, entry_active);
		entry_value = 24'h0000C8;
		press(6);
		step(4);
		chk("tare_kb", 24'h0000C8, tare_value);
		press(2);
		step(4);
		chk("rcl_view", stk_pkg::VIEW_TARE, display_view);
		step(250);
		chk("rcl_to", 24'h000000, recall_active);
		chk("rcl_back", stk_pkg::VIEW_NET, display_view);
		key_timeout_sec = 4'h0;
		press(2);
		step(250);
		chk("rcl_stay", 24'h000001, recall_active);
		press(2);
		step(4);
		press(4);
		step(4);
		chk("unit_val", 24'h000384, display_value);
		chk("label", custom_label, display_label);
		press(4);
		step(4);
		chk("main_val", 24'h000258, display_value);
		target = 24'h000064;
		step(40);
		press(5);
		step(40);
		chk("pr_net", 24'h000064, pn);
		chk("pr_gross", 24'h0000C8, pg);
		chk("pr_tare", 24'h000064, pt);
		foreach (codes[i])
		begin
			select_action = codes[i];
			press(3);
			step(3);
			chk("sel", codes[i], sel_seen);
		end
		select_action = stk_pkg::SEL_NET_GROSS;
		press(3);
		step(3);
		chk("sel_view", stk_pkg::VIEW_GROSS, display_view);
		press(3);
		auto_clear_enable = 1;
		clear_after_print = 1;
		press(5);
		step(40);
		chk("clr_tare", 24'h000000, tare_value);
		chk("clr_view", stk_pkg::VIEW_GROSS, display_view);
		automatic_tare_enable = 1;
		target = 24'h000190;
		step(40);
		chk("auto", 24'h000190, tare_value);
		target = 24'h000014;
		step(40);
		target = 24'h000258;
		step(40);
		chk("rearm", 24'h000258, tare_value);
		clear_after_print = 0;
		step(40);
		target = 24'h000064;
		step(40);
		chk("thr_clr", 24'h000000, tare_value);
		select_action = stk_pkg::SEL_SP1;
		press(3);
		chk("sp1_kind", stk_pkg::ENTRY_SP1, entry_kind);
		entry_value = 24'h000123;
		press(6);
		select_action = stk_pkg::SEL_SP2;
		press(3);
		chk("sp2_kind", stk_pkg::ENTRY_SP2, entry_kind);
		entry_value = 24'h000456;
		press(6);
		step(2);
		chk("sp1", 24'h000123, setpoint1);
		chk("sp2", 24'h000456, setpoint2);
		chk("sp_tare", 24'h000000, tare_value);
		key_timeout_sec = 4'h1;
		press(1);
		chk("to_entry", 24'h000001, entry_active);
		step(250);
		chk("to_back", 24'h000000, entry_active);
		chk("to_view", stk_pkg::VIEW_GROSS, display_view);
		clear_motion_check = 1;
		motion_interval = 4'hA;
		step(120);
		press(0);
		step(4);
		chk("pb2", 24'h000064, tare_value);
		target = 24'h000258;
		step(150);
		target = 24'h000064;
		step(40);
		chk("clr_wait", 24'h000064, tare_value);
		step(120);
		chk("clr_still", 24'h000000, tare_value);
		tare_clear_lockout = 1;
		key_timeout_sec = 4'h0;
		press(0);
		step(4);
		tare_recall_enable = 0;
		gross_recall_enable = 1;
		press(2);
		chk("rcl_gross", stk_pkg::VIEW_GROSS, display_view);
		press(2);
		chk("rcl_ret", stk_pkg::VIEW_NET, display_view);
		target = 24'h000258;
		step(150);
		target = 24'h000064;
		step(150);
		chk("lock_hold", 24'h000064, tare_value);
		target = 24'h000000;
		step(20);
		chk("lock_clr", 24'h000000, tare_value);
		report_and_stop;
	end
endmodule // test_stk_ctrl
bind stk_ctrl stk_ctrl_chk stk_ctrl_chk_i (.sys_clk, .srst, .tare_enable, .sign_correct_enable,
	.second_unit_enable, .tare_recall_enable, .custom_label, .display_view,
	.display_second_unit, .display_label, .warmup_active, .entry_active, .recall_active,
	.no_motion, .tare_value, .net_mode, .print_strobe, .print_gross, .print_tare, .print_net,
	.select_cmd_valid, .select_cmd_code);
